// *** inc/cdu_defs.vh ***
// Register map, field positions, reset values and mode codes of the current DAC control block
`ifndef CDU_DEFS_VH
`define CDU_DEFS_VH

// Number of converters and word widths
`define CDU_NUM_DAC        2
`define CDU_WORD_W         10
`define CDU_NUM_TIMER      4

// Register byte offsets inside one converter's window
`define CDU_OFS_CTRL       8'h00
`define CDU_OFS_LOW        8'h04
`define CDU_OFS_HIGH       8'h08
`define CDU_OFS_WORD       8'h0c

// Distance between the windows of converter zero and converter one
`define CDU_DAC_STRIDE     8'h10

// Control register fields
`define CDU_CTRL_EN_BIT    7
`define CDU_CTRL_MODE_HI   6
`define CDU_CTRL_MODE_LO   4
`define CDU_CTRL_RST       8'h70

// Low data byte: the two least significant word bits sit at the top
`define CDU_LOW_LSB_HI     7
`define CDU_LOW_LSB_LO     6
`define CDU_LOW_RST        8'h00
`define CDU_HIGH_RST       8'h00
`define CDU_WORD_RST       10'h000

// Update-mode codes
`define CDU_MODE_TMR0      3'h0
`define CDU_MODE_TMR1      3'h1
`define CDU_MODE_TMR2      3'h2
`define CDU_MODE_TMR3      3'h3
`define CDU_MODE_RISE      3'h4
`define CDU_MODE_FALL      3'h5
`define CDU_MODE_BOTH      3'h6
`define CDU_MODE_ONDEMAND  3'h7

`endif

// *** logic/cdu_trigger.v ***
// Update-trigger selector for one converter: timer overflow or pin edge
`timescale 1ns/1ps

`include "cdu_defs.vh"

module cdu_trigger (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Selected update mode
    input  wire [2:0] mode_i,
    // Event sources
    input  wire [3:0] timer_ovf_i,
    input  wire       edge_pin_i,
    // One-cycle update request
    output reg        trig_o
);

    reg pin_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Last pin level; inputs are synchronous, so no extra synchroniser here
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= edge_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event decode; on-demand mode never fires here, the bus write does it
    always @* begin
        case (mode_i)
            `CDU_MODE_TMR0: trig_o = timer_ovf_i[0];
            `CDU_MODE_TMR1: trig_o = timer_ovf_i[1];
            `CDU_MODE_TMR2: trig_o = timer_ovf_i[2];
            `CDU_MODE_TMR3: trig_o = timer_ovf_i[3];
            `CDU_MODE_RISE: trig_o = edge_pin_i & ~pin_prev_r;
            `CDU_MODE_FALL: trig_o = ~edge_pin_i & pin_prev_r;
            `CDU_MODE_BOTH: trig_o = edge_pin_i ^ pin_prev_r;
            default:        trig_o = 1'b0;
        endcase
    end

endmodule // cdu_trigger

// *** logic/cdu_top.v ***
// Wishbone-controlled update scheduling and pin hand-over for two 10-bit current DACs
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

`include "cdu_defs.vh"

module cdu_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire        ack_o,
    // Update event sources
    input  wire [3:0]  timer_ovf_i,
    input  wire [1:0]  update_pin_i,
    // GPIO requests from the port logic, one bit per DAC pin
    input  wire [1:0]  gpio_out_i,
    input  wire [1:0]  gpio_oe_i,
    input  wire [1:0]  gpio_pullup_i,
    // Pin controls towards the pads
    output wire [1:0]  pin_out_o,
    output wire [1:0]  pin_oe_o,
    output wire [1:0]  pin_pullup_o,
    output wire [1:0]  dac_connect_o,
    // Converter side
    output wire        bias_en_o,
    output wire [9:0]  dac0_word_o,
    output wire [9:0]  dac1_word_o
);

    // Bus slave states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK  = 2'b10;

    // Loop indices, one per clocked process so neither drives the other's
    integer i;
    integer j;

    // Bus slave
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [31:0] rdata_r;
    reg  [31:0] rdata_nxt;
    wire        req_w;
    wire        wr_fire_w;

    // Per-converter storage, indexed by converter number
    reg  [7:0]  dac_control_register [0:1];
    reg  [7:0]  dac_data_low_byte    [0:1];
    reg  [7:0]  dac_data_high_byte   [0:1];
    reg  [9:0]  word_r               [0:1];

    // Per-converter decoded views
    wire [1:0]  en_w;
    wire [2:0]  mode_w [0:1];
    wire [1:0]  trig_w;
    wire [1:0]  wr_ctrl_w;
    wire [1:0]  wr_low_w;
    wire [1:0]  wr_high_w;
    wire [1:0]  ondemand_w;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: each converter owns a window of four byte registers.
    //   base + 0x00  control: bit 7 enable, bits 6:4 update mode, bits 3:0 read 0
    //   base + 0x04  low data byte: bits 7:6 are word bits 1:0, all eight are kept
    //   base + 0x08  high data byte: word bits 9:2
    //   base + 0x0c  converter word, read only; a write there is acked and dropped
    // Converter zero sits at base 0x00 and converter one at base 0x10. Unmapped
    // offsets ack with zero, so a stray access never hangs the bus.
    //
    // Bus timing: a request is taken while the slave is idle, ack follows one
    // cycle later and stands for one cycle, and the master drops its strobe for
    // at least one cycle before the next request; an access takes three cycles.
    // Read data is captured when the request is taken and stands with ack.
    //
    // Only byte lane zero carries write data; a write with that lane off is acked but
    // changes nothing, so a wider master cannot scribble on a register.
    //
    // Update modes 0 to 3 follow one timer overflow each, 4 to 6 a rising,
    // falling or any edge of the converter's own update pin, and 7 the high-byte
    // write. Commits go on while a converter is disabled, so software can preload
    // a level before it hands the pin over to the converter.
    //
    // Hazard: a byte write and a trigger on one edge commit the old staged word;
    // the new byte waits for the next trigger. Software that must not lose a
    // sample stages its bytes well away from the trigger event.
    //
    // Pins: an enabled converter takes its pin's driver and pull-up away and is
    // wired to the pad; keeping digital functions off that pin is software's
    // job. One bias generator serves both converters while either is enabled.
    //
    // Reset: both converters come up disabled and on-demand with zero words, so
    // every pin starts as plain GPIO and the bias generator is off. The edge
    // detectors start from a low level; that is harmless because the first bus
    // write that can pick an edge mode lands after they have taken the pin level.

    ////////////////////////////////////////////////////////////////////////////
    // Converter word from a high byte and the top two bits of a low byte; both
    // commit paths use it so the word layout lives in one place
    function [9:0] assemble_word;
        input [7:0] high;
        input [7:0] low;
        begin
            assemble_word = {high, low[`CDU_LOW_LSB_HI:`CDU_LOW_LSB_LO]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode shared by the write strobes and the read mux
    function hit;
        input [7:0] adr;
        input       dac;
        input [7:0] ofs;
        begin
            hit = (adr == ((dac ? `CDU_DAC_STRIDE : 8'h00) + ofs));
        end
    endfunction

    // Word read back from a converter's window, zero for unmapped offsets
    function [31:0] read_dac;
        input [7:0] adr;
        input       dac;
        input [7:0] ctrl;
        input [7:0] low;
        input [7:0] high;
        input [9:0] word;
        begin
            if (hit(adr, dac, `CDU_OFS_CTRL)) begin
                read_dac = {24'h000000, ctrl};
            end else if (hit(adr, dac, `CDU_OFS_LOW)) begin
                read_dac = {24'h000000, low};
            end else if (hit(adr, dac, `CDU_OFS_HIGH)) begin
                read_dac = {24'h000000, high};
            end else if (hit(adr, dac, `CDU_OFS_WORD)) begin
                read_dac = {22'h00000, word};
            end else begin
                read_dac = 32'h00000000;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: a request is answered one cycle after it appears, and a
    // write lands on the edge at which the master samples ack high, so a
    // master that drops the request early never commits half a write.
    assign req_w     = cyc_i & stb_i;
    assign wr_fire_w = req_w & we_i & state_r[1] & sel_i[0];
    assign ack_o     = state_r[1];
    assign dat_o     = rdata_r;

    // Next state and read capture. The read mux ORs both windows; they never
    // overlap, so at most one side is non-zero for any address.
    always @* begin
        state_nxt = state_r;
        rdata_nxt = rdata_r;
        case (state_r)
            ST_IDLE: begin
                if (req_w) begin
                    state_nxt = ST_ACK;
                    rdata_nxt = read_dac(adr_i, 1'b0, dac_control_register[0],
                                         dac_data_low_byte[0], dac_data_high_byte[0],
                                         word_r[0])
                              | read_dac(adr_i, 1'b1, dac_control_register[1],
                                         dac_data_low_byte[1], dac_data_high_byte[1],
                                         word_r[1]);
                end
            end
            ST_ACK: begin
                // Ack stands one cycle; the master releases after seeing it
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Bus slave registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            rdata_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-converter strobes, trigger selectors and views
    genvar g;
    generate
        for (g = 0; g < `CDU_NUM_DAC; g = g + 1) begin : g_dac
            // Byte-lane zero carries every register write of this block; writes to the
            // read-only word offset match no strobe and fall away
            assign wr_ctrl_w[g] = wr_fire_w & hit(adr_i, (g != 0), `CDU_OFS_CTRL);
            assign wr_low_w[g]  = wr_fire_w & hit(adr_i, (g != 0), `CDU_OFS_LOW);
            assign wr_high_w[g] = wr_fire_w & hit(adr_i, (g != 0), `CDU_OFS_HIGH);

            assign en_w[g]   = dac_control_register[g][`CDU_CTRL_EN_BIT];
            assign mode_w[g] = dac_control_register[g][`CDU_CTRL_MODE_HI:`CDU_CTRL_MODE_LO];

            // Mode 7 leaves the trigger selector idle; the bus write commits instead
            assign ondemand_w[g] = (mode_w[g] == `CDU_MODE_ONDEMAND);

            // Timer and pin-edge events for this converter; both converters share
            // the four timer overflows
            cdu_trigger u_trig (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .mode_i      (mode_w[g]),
                .timer_ovf_i (timer_ovf_i),
                .edge_pin_i  (update_pin_i[g]),
                .trig_o      (trig_w[g])
            );

            // Pin hand-over: enable takes the driver and pull-up away. The output
            // level still follows the port logic, harmless while its driver is off.
            assign pin_out_o[g]     = gpio_out_i[g];
            assign pin_oe_o[g]      = en_w[g] ? 1'b0 : gpio_oe_i[g];
            assign pin_pullup_o[g]  = en_w[g] ? 1'b0 : gpio_pullup_i[g];
            assign dac_connect_o[g] = en_w[g];
        end
    endgenerate

    // One shared bias generator serves both converters
    assign bias_en_o = |en_w;

    ////////////////////////////////////////////////////////////////////////////
    // Control and staged data bytes. The low byte keeps all eight bits so
    // software reads back what it wrote, though only bits 7:6 reach the word.
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < `CDU_NUM_DAC; i = i + 1) begin
                dac_control_register[i] <= `CDU_CTRL_RST;
                dac_data_low_byte[i]    <= `CDU_LOW_RST;
                dac_data_high_byte[i]   <= `CDU_HIGH_RST;
            end
        end else begin
            for (i = 0; i < `CDU_NUM_DAC; i = i + 1) begin
                // Only enable and mode are stored; the low nibble reads zero
                if (wr_ctrl_w[i]) begin
                    dac_control_register[i] <= {dat_i[7:4], 4'h0};
                end
                // Byte writes stage; the output moves on its own event, or on the high write in on-demand mode
                if (wr_low_w[i]) begin
                    dac_data_low_byte[i] <= dat_i[7:0];
                end
                if (wr_high_w[i]) begin
                    dac_data_high_byte[i] <= dat_i[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter word: on-demand takes the fresh high byte with the staged low
    // bits in the same edge; other modes commit both staged bytes on the
    // selected event. A high write in the trigger's cycle stages for the next.
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (j = 0; j < `CDU_NUM_DAC; j = j + 1) begin
                word_r[j] <= `CDU_WORD_RST;
            end
        end else begin
            for (j = 0; j < `CDU_NUM_DAC; j = j + 1) begin
                if (ondemand_w[j]) begin
                    if (wr_high_w[j]) begin
                        word_r[j] <= assemble_word(dat_i[7:0], dac_data_low_byte[j]);
                    end
                end else if (trig_w[j]) begin
                    word_r[j] <= assemble_word(dac_data_high_byte[j],
                                               dac_data_low_byte[j]);
                end
            end
        end
    end

    // Converter data straight from the word flip-flops
    assign dac0_word_o = word_r[0];
    assign dac1_word_o = word_r[1];

endmodule // cdu_top

// *** tb/cdu_top_chk.sv ***
// Port-level assertions for the current DAC control block
`timescale 1ns/1ps
module cdu_top_chk (
    // Clock, reset and bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire        ack_o,
    // Pins and converter side
    input wire [1:0]  gpio_oe_i,
    input wire [1:0]  gpio_pullup_i,
    input wire [1:0]  pin_oe_o,
    input wire [1:0]  pin_pullup_o,
    input wire [1:0]  dac_connect_o,
    input wire        bias_en_o,
    input wire [9:0]  dac0_word_o,
    input wire [9:0]  dac1_word_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Mode shadows, followed from accepted control writes so commits can be judged
    wire       wr_w = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    reg  [2:0] mode0_r;
    reg  [2:0] mode1_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode0_r <= 3'h7;
            mode1_r <= 3'h7;
        end else if (wr_w) begin
            if (adr_i == 8'h00) mode0_r <= dat_i[6:4];
            if (adr_i == 8'h10) mode1_r <= dat_i[6:4];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Pin hand-over, bias and bus timing
    property p_oe_gate; pin_oe_o == (gpio_oe_i & ~dac_connect_o); endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("pin driver enable wrong for converter state");
    property p_pu_gate; pin_pullup_o == (gpio_pullup_i & ~dac_connect_o); endproperty
    a_pu_gate: assert property (p_pu_gate)
        else $error("pull-up not cut while converter connected");
    property p_bias; bias_en_o == (|dac_connect_o); endproperty
    a_bias: assert property (p_bias)
        else $error("bias generator state wrong");
    property p_ack_lat; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("no acknowledge one cycle after request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
    // Commit and hold in on-demand mode
    property p_commit0; wr_w && adr_i == 8'h08 && mode0_r == 3'h7
        |=> dac0_word_o[9:2] == $past(dat_i[7:0]); endproperty
    a_commit0: assert property (p_commit0)
        else $error("converter zero not committed on high byte write");
    property p_commit1; wr_w && adr_i == 8'h18 && mode1_r == 3'h7
        |=> dac1_word_o[9:2] == $past(dat_i[7:0]); endproperty
    a_commit1: assert property (p_commit1)
        else $error("converter one not committed on high byte write");
    property p_hold0; mode0_r == 3'h7 && !(wr_w && adr_i == 8'h08)
        |=> $stable(dac0_word_o); endproperty
    a_hold0: assert property (p_hold0)
        else $error("converter zero output moved without high byte write");
endmodule // cdu_top_chk

bind cdu_top cdu_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .gpio_oe_i(gpio_oe_i), .gpio_pullup_i(gpio_pullup_i),
    .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .dac_connect_o(dac_connect_o),
    .bias_en_o(bias_en_o), .dac0_word_o(dac0_word_o), .dac1_word_o(dac1_word_o));

// *** tb/cdu_top_bench.sv ***
// Self-checking bench for the current DAC control block
`timescale 1ns/1ps
module cdu_top_bench;
    reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, p;
    reg  [7:0]  adr_i = 0, d;
    reg  [3:0]  sel_i = 4'hf, timer_ovf_i = 0;
    reg  [31:0] dat_i = 0, q;
    reg  [1:0]  update_pin_i = 0, gpio_out_i = 2'h2, gpio_oe_i = 2'h3, gpio_pullup_i = 2'h3;
    wire [31:0] dat_o;
    wire        ack_o, bias_en_o;
    wire [1:0]  pin_out_o, pin_oe_o, pin_pullup_o, dac_connect_o;
    wire [9:0]  dac0_word_o, dac1_word_o;
    reg  [9:0]  exp0;
    integer     errors = 0, compares = 0, k, m;
    always #5 clk_i = ~clk_i;
    cdu_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .timer_ovf_i(timer_ovf_i), .update_pin_i(update_pin_i), .gpio_out_i(gpio_out_i),
        .gpio_oe_i(gpio_oe_i), .gpio_pullup_i(gpio_pullup_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .dac_connect_o(dac_connect_o),
        .bias_en_o(bias_en_o), .dac0_word_o(dac0_word_o), .dac1_word_o(dac1_word_o));
    ////////////////////////////////////////////////////////////////////////
    // Compare with case inequality so an unknown never matches
    task chk(input string nm, input [31:0] e, input [31:0] g); begin
        compares = compares + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
        end
    end endtask
    // Classic single cycle; held until ack is sampled, then one idle cycle.
    // Only the watchdog ends a wait that never sees ack.
    task bus(input w, input [7:0] a, input [7:0] dd);
        begin
            cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h0, dd};
            @(posedge clk_i);
            while (ack_o !== 1'b1) begin
                @(posedge clk_i);
            end
            q = dat_o;
            cyc_i <= 0; stb_i <= 0; we_i <= 0;
            @(posedge clk_i);
        end
    endtask
    // One-cycle timer pulse with a pin level; result is visible after the first of its two edges
    task trig(input [3:0] t, input [1:0] pl); begin
        timer_ovf_i <= t; update_pin_i <= pl;
        @(posedge clk_i);
        timer_ovf_i <= 0;
        @(posedge clk_i);
    end endtask
    task print_verdict; begin
        $display("checks %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end endtask
    // Watchdog: the full sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        errors = errors + 1;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        bus(0, 8'h00, 0); chk("ctrl0", 32'h70, q);
        chk("oe", 3, pin_oe_o); chk("pu", 3, pin_pullup_o);
        chk("out", 2, pin_out_o); chk("bias", 0, bias_en_o);
        bus(1, 8'h04, 8'h40); chk("low held", 0, dac0_word_o);
        bus(1, 8'h08, 8'ha5); chk("word0", 10'h295, dac0_word_o);
        sel_i <= 4'he;
        bus(1, 8'h08, 8'h00); chk("no sel", 10'h295, dac0_word_o);
        sel_i <= 4'hf;
        // Eight-bit use: low byte set once, then high bytes only
        bus(1, 8'h14, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            d = 8'h0f + 8'h55 * k;
            bus(1, 8'h18, d); chk("word1", {d, 2'b00}, dac1_word_o);
        end
        bus(1, 8'h00, 8'hf0); chk("oe en", 2, pin_oe_o);
        chk("pu en", 2, pin_pullup_o); chk("con", 1, dac_connect_o);
        chk("bias en", 1, bias_en_o);
        // Routing skip: port logic drops pin zero and releases pin one
        gpio_oe_i <= 2'h0;
        @(posedge clk_i);
        chk("skip oe", 0, pin_oe_o);
        bus(1, 8'h0c, 8'hff); bus(0, 8'h0c, 0); chk("word ro", 10'h295, q);
        bus(0, 8'h30, 0); chk("unmapped", 0, q);
        // Timer and pin-edge modes: byte writes only stage the word
        exp0 = 10'h295;
        for (m = 0; m < 7; m = m + 1) begin
            bus(1, 8'h00, 8'h80 + m * 16);
            d = 8'h13 + 8'h21 * m;
            bus(1, 8'h08, d); chk("staged", exp0, dac0_word_o);
            if (m < 4) begin
                trig(4'h1 << ((m + 1) % 4), update_pin_i); chk("other tmr", exp0, dac0_word_o);
                trig(4'h1 << m, update_pin_i);
                exp0 = {d, 2'b01};
                chk("tmr upd", exp0, dac0_word_o);
            end else begin
                repeat (2) begin
                    p = ~update_pin_i[0];
                    trig(0, {update_pin_i[1], p});
                    if ((p && m != 5) || (!p && m != 4)) exp0 = {d, 2'b01};
                    chk("pin upd", exp0, dac0_word_o);
                end
            end
        end
        gpio_oe_i <= 2'h3;
        bus(1, 8'h00, 8'h70); trig(4'hf, update_pin_i);
        chk("od ignore", exp0, dac0_word_o); chk("bias off", 0, bias_en_o);
        chk("oe dis", 3, pin_oe_o); chk("pu dis", 3, pin_pullup_o);
        print_verdict;
    end
endmodule // cdu_top_bench
